// File: logic/irq_pkg.sv
`default_nettype none
package irq_pkg;
   // register byte addresses on the wishbone bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SOFT_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_SOFT_SET = 8'h08;
   localparam logic [7:0] ADDR_SOFT_CLR = 8'h0C;
   localparam logic [7:0] ADDR_PENDING = 8'h10;
   localparam logic [7:0] ADDR_PEND_CLR = 8'h14;
   localparam logic [7:0] ADDR_PRIO_SEL = 8'h18;
   localparam logic [7:0] ADDR_STATE = 8'h1C;
   localparam logic [7:0] ADDR_RTC = 8'h20;
   localparam logic [7:0] ADDR_LOW_ENABLED = 8'h24;
   // control register field positions
   localparam int CTRL_TWO_LEVEL = 0;
   localparam int CTRL_HIGH_EN = 1;
   localparam int CTRL_LOW_EN = 2;
   localparam int CTRL_CMP_PRIO = 3;
   localparam logic [3:0] CTRL_RESET = 4'h7;
   // state register field positions
   localparam int ST_IN_HIGH = 0;
   localparam int ST_IN_LOW = 1;
   // soft flag bit values
   localparam logic [7:0] RADIO_CMD_RESPONSE_FLAG = 8'h01;
   localparam logic [7:0] PANEL_MESSAGE_FLAG = 8'h02;
   localparam logic [7:0] RADIO_DATA_FLAG = 8'h04;
   localparam logic [7:0] RESTART_SLAVE_FLAG = 8'h08;
   localparam logic [7:0] REFRESH_DIALOG_FLAG = 8'h10;
   localparam logic [7:0] SECOND_TICK_FLAG = 8'h20;
   localparam logic [7:0] USER_SOFT_FLAG_B = 8'h40;
   localparam logic [7:0] USER_SOFT_FLAG_A = 8'h80;
   localparam logic [7:0] SOFT_FLAGS_RESET = 8'h00;
   // pending source bit positions
   localparam int SRC_PORT_EDGE = 0;
   localparam int SRC_PORT_CHANGE = 4;
   localparam int SRC_TIMER = 5;
   localparam int SRC_SOFT_TIMER = 7;
   localparam int SRC_CAPTURE = 10;
   localparam int SRC_PARALLEL = 15;
   localparam int SRC_ADC = 16;
   localparam int SRC_SYNC_SERIAL = 17;
   localparam int SRC_COMPARATOR = 18;
   localparam int SRC_EEPROM = 19;
   localparam int SRC_BUS_COLL = 20;
   localparam int SRC_LOW_VOLT = 21;
   localparam int SRC_SER1_RX = 22;
   localparam int SRC_SER1_TX = 23;
   localparam int SRC_SER2_RX = 24;
   localparam int NUM_SRC = 25;
   // default priority selection: hardware sources high, soft timer low; comparator bit then follows the control register
   localparam logic [24:0] PRIO_RESET = 25'h1FFFF7F;
   // real-time clock second period
   localparam int CLK_HZ = 50_000_000;
   localparam int SECOND_MS = 1000;
   localparam int SECOND_CYCLES = CLK_HZ / 1000 * SECOND_MS;
   // wishbone request carrier
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   // core-facing handshake carrier
   typedef struct packed {
      logic high_req;
      logic low_req;
   } core_req_t;
endpackage : irq_pkg
`default_nettype wire

// File: logic/prio_irq_ctrl.sv
`default_nettype none
// Function
// - two levels, high preempts low service
// - soft flag raises low request immediately
// - fixed soft flag bit values
// - clock sets tick flag each second
// - time counter advances at high priority
// - low request repeats while flags remain
// - query per flag, clear only named
// - save three registers on high entry
// - low enable state readable
// - separate enables, two-level default
// - readable pending flags for all sources
// - unclaimed interrupts go to user handlers
// - comparator change interrupt, selectable priority
// - reset selects two-level, both enabled
// - soft timer is low source at reset
module prio_irq_ctrl
   import irq_pkg::*;
#(
   parameter int SECOND_COUNT = irq_pkg::SECOND_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire irq_pkg::wb_req_t wb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // interrupt sources, one pulse or level per source
   input wire logic [24:0] src_i,
   // core handshake: enter and return strobes per level
   input wire logic high_enter_i,
   input wire logic high_exit_i,
   input wire logic low_enter_i,
   input wire logic low_exit_i,
   // core requests to vector
   output irq_pkg::core_req_t req_o,
   // context save strobes towards core
   output logic high_save_o,
   output logic low_save_o
);
   import irq_pkg::*;

   typedef enum logic [1:0] {
      LVL_IDLE = 2'b00,
      LVL_LOW = 2'b01,
      LVL_HIGH = 2'b10,
      LVL_HIGH_OVER_LOW = 2'b11
   } level_t;

   logic [3:0] ctrl;
   logic [7:0] soft_int_flags;
   logic [24:0] pending;
   logic [24:0] prio_sel;
   logic [31:0] rtc_seconds;
   logic [31:0] sec_count;
   logic rtc_due;
   level_t level;
   level_t next_level;

   // flag byte masking helper used for set and clear paths
   function automatic logic [7:0] merge_flags(input logic [7:0] cur, input logic [7:0] set,
                                              input logic [7:0] clr);
      merge_flags = (cur & ~clr) | set;
   endfunction

   // bus decode
   wire bus_req = wb_i.cyc & wb_i.stb & ~wb_ack_o;
   wire bus_wr = bus_req & wb_i.we & wb_i.sel[0];
   wire wr_ctrl = bus_wr & (wb_i.adr == ADDR_CTRL);
   wire wr_soft = bus_wr & (wb_i.adr == ADDR_SOFT_FLAGS);
   wire wr_set = bus_wr & (wb_i.adr == ADDR_SOFT_SET);
   wire wr_clr = bus_wr & (wb_i.adr == ADDR_SOFT_CLR);
   wire wr_pclr = bus_wr & (wb_i.adr == ADDR_PEND_CLR);
   wire wr_prio = bus_wr & (wb_i.adr == ADDR_PRIO_SEL);
   wire two_level = ctrl[CTRL_TWO_LEVEL];
   wire high_en = ctrl[CTRL_HIGH_EN];
   wire low_en = ctrl[CTRL_LOW_EN];
   wire second_done = (sec_count == SECOND_COUNT - 1);

   // soft flag updates: hardware tick set wins over clear
   // fixed flag bit
   wire [7:0] tick_set = second_done ? SECOND_TICK_FLAG : 8'h00;
   wire [7:0] clr_mask = wr_clr ? wb_i.dat[7:0] : (wr_soft ? ~wb_i.dat[7:0] : 8'h00);
   wire [7:0] set_mask = (wr_set | wr_soft) ? wb_i.dat[7:0] : 8'h00;
   wire [7:0] next_soft = merge_flags(soft_int_flags, set_mask | tick_set, clr_mask);

   wire soft_timer_req = |soft_int_flags;
   wire [24:0] hw_src = src_i & ~(25'h1 << SRC_SOFT_TIMER);
   wire [24:0] soft_bit = soft_timer_req ? (25'h1 << SRC_SOFT_TIMER) : 25'h0;
   wire [24:0] pclr = wr_pclr ? wb_i.dat[24:0] : 25'h0;
   wire [24:0] next_pending = (pending & ~pclr & ~(25'h1 << SRC_SOFT_TIMER)) | hw_src | soft_bit;

   // level routing, single level when two-level off
   wire [24:0] high_mask = two_level ? prio_sel : {NUM_SRC{1'b1}};
   wire high_any = |(pending & high_mask) & high_en;
   wire low_any = two_level & (|(pending & ~high_mask)) & low_en;

   // level sequencer
   // high preempts low
   always_comb begin
      next_level = level;
      unique case (level)
         LVL_IDLE: begin
            if (high_enter_i) next_level = LVL_HIGH;
            else if (low_enter_i) next_level = LVL_LOW;
         end
         LVL_LOW: begin
            if (high_enter_i) next_level = LVL_HIGH_OVER_LOW;
            else if (low_exit_i) next_level = LVL_IDLE;
         end
         LVL_HIGH: begin
            if (high_exit_i) next_level = LVL_IDLE;
         end
         LVL_HIGH_OVER_LOW: begin
            if (high_exit_i) next_level = LVL_LOW;
         end
      endcase
   end

   wire in_high = (level == LVL_HIGH) | (level == LVL_HIGH_OVER_LOW);
   wire in_low = (level == LVL_LOW) | (level == LVL_HIGH_OVER_LOW);

   // register read mux
   // low enable readback
   wire [31:0] rd_data =
      (wb_i.adr == ADDR_CTRL) ? {28'h0, ctrl} :
      (wb_i.adr == ADDR_SOFT_FLAGS) ? {24'h0, soft_int_flags} :
      (wb_i.adr == ADDR_PENDING) ? {7'h0, pending} :
      (wb_i.adr == ADDR_PRIO_SEL) ? {7'h0, prio_sel} :
      (wb_i.adr == ADDR_STATE) ? {30'h0, in_low, in_high} :
      (wb_i.adr == ADDR_RTC) ? rtc_seconds :
      (wb_i.adr == ADDR_LOW_ENABLED) ? {31'h0, low_en} : 32'h0;

   // bus answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h0;
      end
   end

   // control and priority registers
   // reset two-level, both enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
         prio_sel <= PRIO_RESET;
      end else begin
         if (wr_ctrl) ctrl <= wb_i.dat[3:0];
         if (wr_prio) prio_sel <= wb_i.dat[24:0];
         else prio_sel[SRC_COMPARATOR] <= ctrl[CTRL_CMP_PRIO]; // control bit picks the level
      end
   end

   // flags and pending
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_int_flags <= SOFT_FLAGS_RESET;
         pending <= 25'h0;
      end else begin
         soft_int_flags <= next_soft;
         pending <= next_pending;
      end
   end

   // second counter and time of day, kept in high-priority path
   // time counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_count <= 32'h0;
         rtc_seconds <= 32'h0;
         rtc_due <= 1'b0;
      end else begin
         sec_count <= second_done ? 32'h0 : sec_count + 32'h1;
         rtc_due <= second_done;
         if (rtc_due) rtc_seconds <= rtc_seconds + 32'h1;
      end
   end

   // level state and core strobes
   // low request raised
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level <= LVL_IDLE;
         req_o <= '0;
         high_save_o <= 1'b0;
         low_save_o <= 1'b0;
      end else begin
         level <= next_level;
         req_o.high_req <= high_any & ~in_high;
         req_o.low_req <= low_any & ~in_high & ~in_low & ~low_exit_i;
         high_save_o <= high_enter_i & ~in_high;
         low_save_o <= low_enter_i & (level == LVL_IDLE) & ~high_enter_i;
      end
   end

   // checks
   // soft request check
   a_soft_pending_track: assert property (@(posedge clk_i) disable iff (rst_i)
      pending[SRC_SOFT_TIMER] == $past(|soft_int_flags)) else $error("soft pending mismatch");
   a_high_preempts_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (level == LVL_LOW && high_enter_i) |=> level == LVL_HIGH_OVER_LOW)
      else $error("high did not preempt");
   a_tick_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      second_done |=> soft_int_flags[5]) else $error("tick flag missing");
   a_low_req_raise: assert property (@(posedge clk_i) disable iff (rst_i)
      (low_any && level == LVL_IDLE && !low_exit_i) |=> req_o.low_req)
      else $error("low request not raised");
   a_clear_named: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_clr && !second_done) |=> soft_int_flags == ($past(soft_int_flags) & ~$past(wb_i.dat[7:0])))
      else $error("clear hit other flags");
   a_low_state_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_req && wb_i.adr == ADDR_LOW_ENABLED) |=> wb_dat_o[0] == $past(low_en))
      else $error("low state readback wrong");
   a_high_save: assert property (@(posedge clk_i) disable iff (rst_i)
      (high_enter_i && !in_high) |=> high_save_o) else $error("high save missing");
   a_rtc_advance: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_due |=> rtc_seconds == $past(rtc_seconds) + 32'h1) else $error("rtc stalled");
   a_high_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
      !high_en |=> !req_o.high_req) else $error("high request while disabled");
   c_nested: cover property (@(posedge clk_i) level == LVL_HIGH_OVER_LOW);
   c_soft_req: cover property (@(posedge clk_i) req_o.low_req);
   c_tick: cover property (@(posedge clk_i) second_done);
endmodule // prio_irq_ctrl
`default_nettype wire

// File: bench/core_model.sv
`default_nettype none
module core_model
   import irq_pkg::*;
(
   // clock, reset and run gate
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   // requests and save strobes
   input wire irq_pkg::core_req_t req_i,
   input wire logic high_save_i,
   input wire logic low_save_i,
   // entry and return strobes
   output logic high_enter_o,
   output logic high_exit_o,
   output logic low_enter_o,
   output logic low_exit_o,
   // event counts
   output int n_high,
   output int n_hsave,
   output int n_low,
   output int n_lsave,
   output int n_pre
);
   int hcnt;
   int lcnt;
   // handler sequencing, low work frozen while high runs
   // short high task, low never nested
   always @(posedge clk_i) begin
      if (rst_i) begin
         {hcnt, lcnt, n_high, n_hsave, n_low, n_lsave, n_pre} <= '0;
         {high_enter_o, high_exit_o, low_enter_o, low_exit_o} <= 4'h0;
      end else begin
         n_hsave <= n_hsave + int'(high_save_i);
         n_lsave <= n_lsave + int'(low_save_i);
         high_enter_o <= 1'b0;
         low_enter_o <= 1'b0;
         high_exit_o <= (hcnt == 3);
         low_exit_o <= (lcnt == 3 && hcnt == 0);
         if (hcnt != 0) hcnt <= hcnt - 1;
         else if (run_i && req_i.high_req) begin
            high_enter_o <= 1'b1;
            hcnt <= 10;
            n_high <= n_high + 1;
            n_pre <= n_pre + int'(lcnt != 0);
         end
         if (lcnt != 0 && hcnt == 0) lcnt <= lcnt - 1;
         else if (lcnt == 0 && hcnt == 0 && run_i && req_i.low_req && !req_i.high_req) begin
            low_enter_o <= 1'b1;
            lcnt <= 40;
            n_low <= n_low + 1;
         end
      end
   end
endmodule // core_model
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_pkg::*;
   localparam int SC = 2000;
   logic clk_i, rst_i, run, wb_ack_o, high_save_o, low_save_o, he, hx, le, lx;
   wb_req_t wb;
   logic [31:0] wb_dat_o, seed, rd, r0;
   logic [24:0] src_i;
   core_req_t req_o;
   logic [7:0] exp_f, v;
   int n_high, n_hsave, n_low, n_lsave, n_pre, failures, comparisons;
   prio_irq_ctrl #(.SECOND_COUNT(SC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src_i), .high_enter_i(he),
      .high_exit_i(hx), .low_enter_i(le), .low_exit_i(lx), .req_o(req_o),
      .high_save_o(high_save_o), .low_save_o(low_save_o));
   core_model core (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .req_i(req_o),
      .high_save_i(high_save_o), .low_save_i(low_save_o), .high_enter_o(he),
      .high_exit_o(hx), .low_enter_o(le), .low_exit_o(lx), .n_high(n_high),
      .n_hsave(n_hsave), .n_low(n_low), .n_lsave(n_lsave), .n_pre(n_pre));
   // xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic wishbone cycle, read data kept in rd
   task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb <= '{1'b1, 1'b1, we, a, 4'hF, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb <= '0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wbx(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic pulse(input int k);
      src_i <= 25'h1 << k;
      @(posedge clk_i);
      src_i <= '0;
   endtask
   task stop_test;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // free running clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      stop_test;
   end
   // main sequence
   initial begin
      rst_i <= 1'b1;
      run <= 1'b0;
      wb <= '0;
      src_i <= '0;
      seed = 32'd74440;
      failures = 0;
      comparisons = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(ADDR_CTRL, 32'h7);
      rdc(ADDR_PRIO_SEL, 32'(PRIO_RESET & ~(25'h1 << SRC_COMPARATOR)));
      rdc(ADDR_LOW_ENABLED, 32'h1);
      rdc(8'h30, 32'h0);
      chk(32'(req_o), 32'h0);
      exp_f = 8'h00;
      for (int i = 0; i < 16; i++) begin
         wbx(1'b1, i < 8 ? ADDR_SOFT_SET : ADDR_SOFT_CLR, 32'h1 << (i % 8));
         exp_f = i < 8 ? exp_f | (8'h01 << i) : exp_f & ~(8'h01 << (i - 8));
         rdc(ADDR_SOFT_FLAGS, {24'h0, exp_f});
         chk(32'(req_o.low_req), 32'(exp_f != 8'h00));
      end
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         v = seed[7:0];
         wbx(1'b1, seed[8] ? ADDR_SOFT_SET : ADDR_SOFT_CLR, {24'h0, v});
         exp_f = seed[8] ? exp_f | v : exp_f & ~v;
         rdc(ADDR_SOFT_FLAGS, {24'h0, exp_f});
         chk(32'(req_o.low_req), 32'(exp_f != 8'h00));
      end
      wbx(1'b1, ADDR_SOFT_FLAGS, 32'h40);
      wbx(1'b1, ADDR_CTRL, 32'h3);
      rdc(ADDR_LOW_ENABLED, 32'h0);
      chk(32'(req_o.low_req), 32'h0);
      wbx(1'b1, ADDR_CTRL, 32'h7);
      rdc(ADDR_SOFT_FLAGS, 32'h40);
      chk(32'(req_o.low_req), 32'h1);
      for (int k = 0; k < NUM_SRC; k++) begin
         if (k != SRC_SOFT_TIMER && k != SRC_COMPARATOR) begin
            pulse(k);
            rdc(ADDR_PENDING, (32'h1 << k) | (32'h1 << SRC_SOFT_TIMER));
            chk(32'(req_o.high_req), 32'h1);
            wbx(1'b1, ADDR_PEND_CLR, 32'h1 << k);
            rdc(ADDR_PENDING, 32'h1 << SRC_SOFT_TIMER);
         end
      end
      pulse(SRC_COMPARATOR);
      rdc(ADDR_PENDING, (32'h1 << SRC_COMPARATOR) | (32'h1 << SRC_SOFT_TIMER));
      chk(32'(req_o.high_req), 32'h0);
      wbx(1'b1, ADDR_CTRL, 32'hF);
      repeat (2) @(posedge clk_i);
      chk(32'(req_o.high_req), 32'h1);
      wbx(1'b1, ADDR_CTRL, 32'hD);
      chk(32'(req_o.high_req), 32'h0);
      wbx(1'b1, ADDR_CTRL, 32'h7);
      wbx(1'b1, ADDR_PEND_CLR, 32'h1 << SRC_COMPARATOR);
      run <= 1'b1;
      while (n_low == 0) @(posedge clk_i);
      pulse(SRC_PORT_EDGE);
      while (n_high == 0) @(posedge clk_i);
      rdc(ADDR_STATE, 32'h3);
      wbx(1'b1, ADDR_PEND_CLR, 32'h1);
      wbx(1'b1, ADDR_SOFT_FLAGS, 32'h0);
      repeat (60) @(posedge clk_i);
      chk(n_pre, 1);
      chk(n_hsave, n_high);
      chk(n_lsave, n_low);
      rdc(ADDR_STATE, 32'h0);
      run <= 1'b0;
      wbx(1'b0, ADDR_RTC, 32'h0);
      r0 = rd;
      repeat (3 * SC) @(posedge clk_i);
      wbx(1'b0, ADDR_RTC, 32'h0);
      chk(32'(rd - r0 == 3 || rd - r0 == 4), 32'h1);
      rdc(ADDR_SOFT_FLAGS, 32'(SECOND_TICK_FLAG));
      stop_test;
   end
endmodule // testbench
`default_nettype wire
